//--- hw/mode_ctrl_pkg.sv
// Package with the layout, reset value and timing of the port mode control register.
package mode_ctrl_pkg;
    localparam logic [4:0] REG_ADDR_MODE = 5'h00;
    localparam int BIT_SW_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED_LSB = 13;
    localparam int BIT_AN_ENABLE = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AN_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    localparam int BIT_SPEED_MSB = 6;
    localparam int BIT_UNIDIR = 5;
    localparam logic [15:0] MODE_RESET = 16'h1040;
    localparam logic [15:0] MODE_WMASK = 16'hffe0;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] SPEED_RSVD = 2'h3;
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int SW_RESET_TIME_NS = 1000;
    localparam int SW_RESET_CYCLES =
        (SW_RESET_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
endpackage

//--- hw/port_mode_control.sv
// Port mode control register with its control decode toward the port logic.
`timescale 1ns/1ps
// Summary of operation
// R1 - Software reset restores defaults, then self-clears.
// R2 - Controller waits 1 us after reset.
// R3 - Loopback uses configured speed and duplex.
// R4 - Speed code bit6 MSB, bit13 LSB.
// R5 - Bit 12 enables autonegotiation, resets to one.
// R6 - Isolate disables MAC outputs, ignores inputs.
// R7 - Restart autonegotiation pulses, then self-clears.
// R8 - Duplex one full, zero half.
// R9 - Bit 7 enables collision test.
// R10 - Unidirectional only when autoneg off, full duplex.
// R11 - Fiber unidirectional transmits regardless of link.
// R12 - Software sets master/slave before forced gigabit.
// R13 - Software powers down after forced-gigabit link drop.
// R14 - Software polls until reset bit clears.
// R15 - Power-down halts media, management stays alive.
// R16 - Reserved bits 4:0 read zero.
module port_mode_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic link_up,
    input wire logic fiber_mode,
    input wire logic mac_tx_en,
    output logic [15:0] reg_rdata,
    output logic rst_busy,
    output logic sw_reset_pulse,
    output logic an_restart_pulse,
    output logic loopback_en,
    output logic [1:0] speed_sel,
    output logic an_enable,
    output logic power_down,
    output logic media_active,
    output logic mac_out_en,
    output logic mac_tx_gated,
    output logic full_duplex,
    output logic col_test_en,
    output logic tx_allowed
);
    logic [15:0] mode_r, mode_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [7:0] rst_cnt_r, rst_cnt_nxt;
    logic rst_pls_r, rst_pls_nxt;
    logic an_pls_r, an_pls_nxt;
    logic [1:0] link_sync_r, fiber_sync_r, tx_sync_r;
    logic tx_allowed_r, tx_allowed_nxt;
    logic gated_r, gated_nxt;
    logic media_r, media_nxt;
    logic mac_en_r, mac_en_nxt;
    logic sel;
    localparam int RST_DELAY = mode_ctrl_pkg::SW_RESET_CYCLES;

    assign sel = reg_addr == mode_ctrl_pkg::REG_ADDR_MODE;

    always_comb begin
        mode_nxt = mode_r;
        rst_cnt_nxt = rst_cnt_r;
        rst_pls_nxt = 1'b0;
        an_pls_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (rst_cnt_r != 8'h00) begin
            rst_cnt_nxt = rst_cnt_r - 8'h01;
            if (rst_cnt_r == 8'h01) begin
                mode_nxt = mode_ctrl_pkg::MODE_RESET; // R1
            end
        end else if (reg_wr && sel) begin
            mode_nxt = reg_wdata & mode_ctrl_pkg::MODE_WMASK; // R16
            mode_nxt[mode_ctrl_pkg::BIT_AN_RESTART] = 1'b0; // R7
            an_pls_nxt = reg_wdata[mode_ctrl_pkg::BIT_AN_RESTART]; // R7
            if (reg_wdata[mode_ctrl_pkg::BIT_SW_RESET]) begin
                rst_pls_nxt = 1'b1; // R1
                rst_cnt_nxt = 8'(mode_ctrl_pkg::SW_RESET_CYCLES); // R1
            end
        end
        if (reg_rd) begin
            rdata_nxt = sel ? mode_r : 16'h0000; // R16
        end
        media_nxt = !mode_nxt[mode_ctrl_pkg::BIT_POWER_DOWN]; // R15
        mac_en_nxt = !mode_nxt[mode_ctrl_pkg::BIT_ISOLATE]; // R6
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= mode_ctrl_pkg::MODE_RESET; // R5
            rdata_r <= 16'h0000;
            rst_cnt_r <= 8'h00;
            rst_pls_r <= 1'b0;
            an_pls_r <= 1'b0;
            media_r <= !mode_ctrl_pkg::MODE_RESET[
                mode_ctrl_pkg::BIT_POWER_DOWN];
            mac_en_r <= !mode_ctrl_pkg::MODE_RESET[
                mode_ctrl_pkg::BIT_ISOLATE];
        end else begin
            mode_r <= mode_nxt;
            rdata_r <= rdata_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            rst_pls_r <= rst_pls_nxt;
            an_pls_r <= an_pls_nxt;
            media_r <= media_nxt;
            mac_en_r <= mac_en_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_sync_r <= 2'h0;
            fiber_sync_r <= 2'h0;
            tx_sync_r <= 2'h0;
        end else begin
            link_sync_r <= {link_sync_r[0], link_up};
            fiber_sync_r <= {fiber_sync_r[0], fiber_mode};
            tx_sync_r <= {tx_sync_r[0], mac_tx_en};
        end
    end

    always_comb begin
        // Unidirectional applies only with autoneg off and full duplex.
        if (!mode_r[mode_ctrl_pkg::BIT_AN_ENABLE] && // R10
            mode_r[mode_ctrl_pkg::BIT_DUPLEX] && fiber_sync_r[1] &&
            mode_r[mode_ctrl_pkg::BIT_UNIDIR]) begin
            tx_allowed_nxt = !mode_r[mode_ctrl_pkg::BIT_POWER_DOWN]; // R11
        end else begin
            tx_allowed_nxt = link_sync_r[1] && // R11
                !mode_r[mode_ctrl_pkg::BIT_POWER_DOWN]; // R15
        end
        gated_nxt = tx_sync_r[1] && // R6
            !mode_r[mode_ctrl_pkg::BIT_ISOLATE];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_allowed_r <= 1'b0;
            gated_r <= 1'b0;
        end else begin
            tx_allowed_r <= tx_allowed_nxt;
            gated_r <= gated_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign rst_busy = mode_r[mode_ctrl_pkg::BIT_SW_RESET]; // R14
    assign sw_reset_pulse = rst_pls_r;
    assign an_restart_pulse = an_pls_r; // R7
    assign loopback_en = mode_r[mode_ctrl_pkg::BIT_LOOPBACK]; // R3
    assign speed_sel = {mode_r[mode_ctrl_pkg::BIT_SPEED_MSB], // R4
                        mode_r[mode_ctrl_pkg::BIT_SPEED_LSB]};
    assign an_enable = mode_r[mode_ctrl_pkg::BIT_AN_ENABLE]; // R5
    assign power_down = mode_r[mode_ctrl_pkg::BIT_POWER_DOWN]; // R15
    assign media_active = media_r; // R15
    assign mac_out_en = mac_en_r; // R6
    assign mac_tx_gated = gated_r; // R6
    assign full_duplex = mode_r[mode_ctrl_pkg::BIT_DUPLEX]; // R8
    assign col_test_en = mode_r[mode_ctrl_pkg::BIT_COL_TEST]; // R9
    assign tx_allowed = tx_allowed_r;

    property p_reset_default;
        @(posedge clk) disable iff (sys_rst)
        rst_pls_r |-> ##RST_DELAY
            (mode_r == mode_ctrl_pkg::MODE_RESET);
    endproperty
    a_reset_default: assert property (p_reset_default) // R1
        else $error("Software reset did not restore defaults.");

    property p_busy_hold;
        @(posedge clk) disable iff (sys_rst)
        rst_cnt_r > 8'h01 |=> $stable(mode_r);
    endproperty
    a_busy_hold: assert property (p_busy_hold) // R1
        else $error("Register changed during software reset.");

    property p_reserved_zero;
        @(posedge clk) disable iff (sys_rst)
        $past(reg_rd) && $past(sel) |-> reg_rdata[4:0] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R16
        else $error("Reserved bits read nonzero.");

    sequence s_restart_wr;
        reg_wr && sel && rst_cnt_r == 8'h00 &&
            reg_wdata[mode_ctrl_pkg::BIT_AN_RESTART];
    endsequence
    property p_restart;
        @(posedge clk) disable iff (sys_rst)
        s_restart_wr |=> an_restart_pulse &&
            !mode_r[mode_ctrl_pkg::BIT_AN_RESTART] ##1 !an_restart_pulse;
    endproperty
    a_restart: assert property (p_restart) // R7
        else $error("Restart did not pulse once and self-clear.");

    property p_isolate;
        @(posedge clk) disable iff (sys_rst)
        mode_r[mode_ctrl_pkg::BIT_ISOLATE] |=> !mac_tx_gated;
    endproperty
    a_isolate: assert property (p_isolate) // R6
        else $error("MAC input passed while isolated.");

    property p_unidir_off;
        @(posedge clk) disable iff (sys_rst)
        (mode_r[mode_ctrl_pkg::BIT_AN_ENABLE] || !full_duplex) &&
            !link_sync_r[1] |=> !tx_allowed;
    endproperty
    a_unidir_off: assert property (p_unidir_off) // R10
        else $error("Unidirectional bit acted while ignored.");

    property p_power_down;
        @(posedge clk) disable iff (sys_rst)
        power_down |=> !tx_allowed;
    endproperty
    a_power_down: assert property (p_power_down) // R15
        else $error("Transmit allowed in power-down.");

    property p_speed;
        @(posedge clk) disable iff (sys_rst)
        reg_wr && sel && rst_cnt_r == 8'h00 |=>
            speed_sel == {$past(reg_wdata[mode_ctrl_pkg::BIT_SPEED_MSB]),
                          $past(reg_wdata[mode_ctrl_pkg::BIT_SPEED_LSB])};
    endproperty
    a_speed: assert property (p_speed) // R4
        else $error("Speed code bit order wrong.");

    property p_write_takes;
        @(posedge clk) disable iff (sys_rst)
        reg_wr && sel && rst_cnt_r == 8'h00 &&
            !reg_wdata[mode_ctrl_pkg::BIT_SW_RESET] |=>
            full_duplex == $past(reg_wdata[mode_ctrl_pkg::BIT_DUPLEX]) &&
            col_test_en == $past(reg_wdata[mode_ctrl_pkg::BIT_COL_TEST]);
    endproperty
    a_write_takes: assert property (p_write_takes) // R8
        else $error("Duplex or collision test write lost.");
endmodule // port_mode_control

//--- test/mgmt_model.sv
// Management controller model that issues register accesses.
`timescale 1ns/1ps
module mgmt_model (
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [15:0] d);
        wr_at(5'h00, d);
    endtask
    task automatic wr_at(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        q = reg_rdata;
    endtask
    task automatic wait_reset(output logic [15:0] q);
        repeat (mode_ctrl_pkg::SW_RESET_CYCLES) @(negedge clk);
        q = 16'hffff;
        for (int i = 0; i < 8 && q[15] !== 1'b0; i++) rd(5'h00, q);
    endtask
endmodule // mgmt_model

//--- test/tb_port_mode_control.sv
// Self-checking bench for the port mode control register.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_port_mode_control;
    logic clk, sys_rst, reg_wr, reg_rd, link_up, fiber_mode, mac_tx_en;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic rst_busy, sw_reset_pulse, an_restart_pulse, loopback_en;
    logic an_enable, power_down, media_active, mac_out_en, mac_tx_gated;
    logic full_duplex, col_test_en, tx_allowed;
    logic [1:0] speed_sel;
    int n_errors = 0;
    int tests_run = 0;
    port_mode_control i_port_mode_control (.clk(clk), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .link_up(link_up), .fiber_mode(fiber_mode),
        .mac_tx_en(mac_tx_en), .reg_rdata(reg_rdata), .rst_busy(rst_busy),
        .sw_reset_pulse(sw_reset_pulse),
        .an_restart_pulse(an_restart_pulse), .loopback_en(loopback_en),
        .speed_sel(speed_sel), .an_enable(an_enable),
        .power_down(power_down), .media_active(media_active),
        .mac_out_en(mac_out_en), .mac_tx_gated(mac_tx_gated),
        .full_duplex(full_duplex), .col_test_en(col_test_en),
        .tx_allowed(tx_allowed));
    mgmt_model i_mgmt_model (.clk(clk), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_defaults();
        i_mgmt_model.rd(5'h00, q);
        `CHK("reset", mode_ctrl_pkg::MODE_RESET, q)
        `CHK("an", 1'b1, an_enable)
        `CHK("speed", 2'h2, speed_sel)
        `CHK("col", 1'b0, col_test_en)
        `CHK("media", 1'b1, media_active)
        `CHK("gated", 1'b1, mac_tx_gated)
        i_mgmt_model.rd(5'h03, q);
        `CHK("unmap", 16'h0000, q)
    endtask
    task automatic t_all_ones();
        i_mgmt_model.wr(16'h7fff);
        `CHK("restart", 1'b1, an_restart_pulse)
        `CHK("loop", 1'b1, loopback_en)
        `CHK("off", 1'b0, media_active)
        `CHK("pd", 1'b1, power_down)
        `CHK("isol", 1'b0, mac_out_en)
        `CHK("col", 1'b1, col_test_en)
        repeat (4) @(negedge clk);
        `CHK("gated", 1'b0, mac_tx_gated)
        `CHK("txpd", 1'b0, tx_allowed)
        `CHK("rsfall", 1'b0, an_restart_pulse)
        i_mgmt_model.rd(5'h00, q);
        `CHK("rdback", 16'h7de0, q)
    endtask
    task automatic t_soft_reset();
        i_mgmt_model.wr(16'h8000);
        `CHK("pulse", 1'b1, sw_reset_pulse)
        `CHK("busy", 1'b1, rst_busy)
        i_mgmt_model.wait_reset(q);
        `CHK("sreset", mode_ctrl_pkg::MODE_RESET, q)
        `CHK("media", 1'b1, media_active)
        `CHK("idle", 1'b0, rst_busy)
    endtask
    task automatic t_speeds();
        i_mgmt_model.wr_at(5'h09, 16'h0800);
        for (int i = 0; i < 4; i++) begin
            i_mgmt_model.wr(16'h4100 | (16'(i & 1) << 13) | (16'(i >> 1) << 6));
            `CHK("speed", 2'(i), speed_sel)
            `CHK("fdx", 1'b1, full_duplex)
            `CHK("loop", 1'b1, loopback_en)
        end
    endtask
    task automatic check_tx(input logic [15:0] w, input logic l,
        input logic e);
        link_up = l;
        i_mgmt_model.wr(w);
        repeat (4) @(negedge clk);
        `CHK("tx", e, tx_allowed)
    endtask
    task automatic t_gig_drop();
        i_mgmt_model.wr(16'h0140);
        link_up = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("gdrop", 1'b0, tx_allowed)
        i_mgmt_model.wr(16'h0940);
        `CHK("gpd", 1'b1, power_down)
        i_mgmt_model.wr(16'h0140);
        link_up = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("gup", 1'b1, tx_allowed)
    endtask
    task automatic t_hw_reset();
        i_mgmt_model.wr(16'h0000);
        `CHK("anoff", 1'b0, an_enable)
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        `CHK("anon", 1'b1, an_enable)
        i_mgmt_model.rd(5'h00, q);
        `CHK("hwrst", mode_ctrl_pkg::MODE_RESET, q)
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        sys_rst = 1'b1;
        link_up = 1'b1;
        fiber_mode = 1'b1;
        mac_tx_en = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        t_defaults();
        t_all_ones();
        t_soft_reset();
        t_speeds();
        check_tx(16'h0120, 1'b0, 1'b1);
        check_tx(16'h1120, 1'b0, 1'b0);
        check_tx(16'h0020, 1'b0, 1'b0);
        check_tx(16'h0100, 1'b0, 1'b0);
        check_tx(16'h0100, 1'b1, 1'b1);
        fiber_mode = 1'b0;
        check_tx(16'h0120, 1'b0, 1'b0);
        t_gig_drop();
        t_hw_reset();
        end_of_test();
    end
endmodule // tb_port_mode_control
